// ### isp_consts.vh
`ifndef ISP_CONSTS_VH
`define ISP_CONSTS_VH
// ==========================================
// geometry
`define ISP_CHANNELS 8
`define ISP_SLOTS 6
`define ISP_STAT_BITS 48
`define ISP_ALL_BITS 384
// ==========================================
// register indices, byte address is four times the index
`define ISP_IDX_CH_SUMMARY 8'h6e
`define ISP_IDX_CHIP_SUMMARY 12'h06f
`define ISP_IDX_VIS_CTRL 12'h080
`define ISP_IDX_STAT1 8'h69
`define ISP_IDX_STAT2 8'h6a
`define ISP_IDX_STAT3 8'h6b
`define ISP_IDX_STAT4 8'h6c
`define ISP_IDX_STAT6 8'h6d
`define ISP_IDX_STAT7 8'hd8
`define ISP_IDX_MASK1 8'h71
`define ISP_IDX_MASK2 8'h72
`define ISP_IDX_MASK3 8'h73
`define ISP_IDX_MASK4 8'h74
`define ISP_IDX_MASK6 8'h76
`define ISP_IDX_MASK7 8'h77
// ==========================================
// fields and reset values
`define ISP_VIS_BIT 0
`define ISP_STAT_RESET 8'h00
`define ISP_MASK_RESET 8'hff
`define ISP_VIS_RESET 1'b0
`define ISP_SUMMARY_RESET 8'h00
`endif

// ### isp_channel.v
`timescale 1ns/1ps
`default_nettype none
`include "isp_consts.vh"

module isp_channel (
    input wire mclk,
    input wire reset,
    input wire [47:0] evSet,
    input wire [5:0] clrStrobe,
    input wire [5:0] maskWe,
    input wire [7:0] maskData,
    input wire visibility,
    output wire [47:0] statusFlat,
    output wire [47:0] maskFlat,
    output wire [7:0] summary
);
    wire [5:0] pend;

    // ==========================================
    // event-status and mask storage, one slot per existing register
    genvar s;
    generate
        for (s = 0; s < `ISP_SLOTS; s = s + 1) begin : gSlot
            reg [7:0] stat;
            reg [7:0] mask;
            wire [7:0] next_stat;
            // masked events are only stored while visibility is on
            // a new event in the clearing cycle survives the clear
            assign next_stat = (stat & ~{8{clrStrobe[s]}}) | (evSet[s*8 +: 8] & (~mask | {8{visibility}}));
            always @(posedge mclk) begin
                if (reset) begin
                    stat <= `ISP_STAT_RESET;
                    mask <= `ISP_MASK_RESET;
                end else begin
                    stat <= next_stat;
                    if (maskWe[s]) begin
                        mask <= maskData;
                    end
                end
            end
            // visible-but-masked bits never count as pending
            assign pend[s] = |(stat & ~mask);
            assign statusFlat[s*8 +: 8] = stat;
            assign maskFlat[s*8 +: 8] = mask;
        end
    endgenerate

    // ==========================================
    // summary pointers
    assign summary[0] = 1'b0;
    assign summary[4:1] = pend[3:0];
    assign summary[5] = 1'b0;
    assign summary[6] = pend[4];
    assign summary[7] = pend[5];
endmodule // isp_channel

`default_nettype wire

// ### isp_summary.v
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "isp_consts.vh"

module isp_summary (
    input wire mclk,
    input wire reset,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [13:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire [383:0] evSet,
    output reg eventPending
);
    // ==========================================
    // decode
    wire [11:0] regIdx;
    wire [2:0] chanSel;
    wire [7:0] lowIdx;
    wire accept;
    reg [3:0] statDec;
    reg [3:0] maskDec;
    reg visibility;
    wire [`ISP_ALL_BITS-1:0] statAll;
    wire [`ISP_ALL_BITS-1:0] maskAll;
    wire [63:0] summaryAll;
    wire [7:0] chipSummary;
    wire [47:0] clrVec;
    wire [47:0] maskWeVec;
    wire [8:0] slotBase;
    wire [5:0] flatIdx;
    reg [7:0] readByte;

    assign regIdx = wb_adr_i[13:2];
    assign chanSel = regIdx[10:8];
    assign lowIdx = regIdx[7:0];
    // one access per bus cycle: ack blocks a second take of the same request
    assign accept = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    // status offset to {hit, slot}
    always @* begin
        statDec = 4'h0;
        if (!regIdx[11]) begin
            case (lowIdx)
                `ISP_IDX_STAT1: statDec = 4'h8;
                `ISP_IDX_STAT2: statDec = 4'h9;
                `ISP_IDX_STAT3: statDec = 4'ha;
                `ISP_IDX_STAT4: statDec = 4'hb;
                `ISP_IDX_STAT6: statDec = 4'hc;
                `ISP_IDX_STAT7: statDec = 4'hd;
                default: statDec = 4'h0;
            endcase
        end
    end

    // mask offset to {hit, slot}
    always @* begin
        maskDec = 4'h0;
        if (!regIdx[11]) begin
            case (lowIdx)
                `ISP_IDX_MASK1: maskDec = 4'h8;
                `ISP_IDX_MASK2: maskDec = 4'h9;
                `ISP_IDX_MASK3: maskDec = 4'ha;
                `ISP_IDX_MASK4: maskDec = 4'hb;
                `ISP_IDX_MASK6: maskDec = 4'hc;
                `ISP_IDX_MASK7: maskDec = 4'hd;
                default: maskDec = 4'h0;
            endcase
        end
    end

    // ==========================================
    // strobes to the channels
    assign flatIdx = {3'h0, chanSel} * 6'd6 + (wb_we_i ? {3'h0, maskDec[2:0]} : {3'h0, statDec[2:0]});
    // the clear fires only on the accepting edge, so a read clears exactly once
    assign clrVec = (accept && !wb_we_i && statDec[3]) ? (48'h1 << flatIdx) : 48'h0;
    // data is eight bits wide in the low lane
    assign maskWeVec = (accept && wb_we_i && wb_sel_i[0] && maskDec[3]) ? (48'h1 << flatIdx) : 48'h0;

    always @(posedge mclk) begin
        if (reset) begin
            visibility <= `ISP_VIS_RESET;
        end else if (accept && wb_we_i && wb_sel_i[0] && regIdx == `ISP_IDX_VIS_CTRL) begin
            visibility <= wb_dat_i[`ISP_VIS_BIT];
        end
    end

    // ==========================================
    // channels
    genvar c;
    generate
        for (c = 0; c < `ISP_CHANNELS; c = c + 1) begin : gChan
            isp_channel uChan (
                .mclk(mclk),
                .reset(reset),
                .evSet(evSet[c*48 +: 48]),
                .clrStrobe(clrVec[c*6 +: 6]),
                .maskWe(maskWeVec[c*6 +: 6]),
                .maskData(wb_dat_i[7:0]),
                .visibility(visibility),
                .statusFlat(statAll[c*48 +: 48]),
                .maskFlat(maskAll[c*48 +: 48]),
                .summary(summaryAll[c*8 +: 8])
            );
            // bit c stands for channel c+1, so bit 7 is channel 8
            assign chipSummary[c] = |summaryAll[c*8 +: 8];
        end
    endgenerate

    // ==========================================
    // read mux
    assign slotBase = {6'h0, chanSel} * 9'd48 + {6'h0, (wb_we_i ? maskDec[2:0] : statDec[2:0])} * 9'd8;

    always @* begin
        readByte = 8'h00;
        if (regIdx == `ISP_IDX_CHIP_SUMMARY) begin
            readByte = chipSummary;
        end else if (regIdx == `ISP_IDX_VIS_CTRL) begin
            readByte = {7'h00, visibility};
        end else if (!regIdx[11] && lowIdx == `ISP_IDX_CH_SUMMARY) begin
            readByte = summaryAll[{chanSel, 3'h0} +: 8];
        end else if (statDec[3]) begin
            readByte = statAll[slotBase +: 8];
        end else if (maskDec[3]) begin
            readByte = maskAll[{6'h0, chanSel} * 9'd48 + {6'h0, maskDec[2:0]} * 9'd8 +: 8];
        end
    end

    // ==========================================
    // bus answer and pending output
    // unmapped addresses still ack and read zero, so the master never hangs
    always @(posedge mclk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            eventPending <= 1'b0;
        end else begin
            wb_ack_o <= accept;
            if (accept && !wb_we_i) begin
                wb_dat_o <= {24'h000000, readByte};
            end
            eventPending <= |chipSummary;
        end
    end
endmodule // isp_summary

`default_nettype wire

// ### isp_chk_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// bus and summary checks
module isp_chk (
    input wire logic mclk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [13:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic eventPending
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    wire logic tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic rd = wb_ack_o && !wb_we_i;
    wire logic [11:0] ix = wb_adr_i[13:2];
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    a_take_ack: assert property (tk |=> wb_ack_o) else $error("no ack");
    a_ack_cause: assert property (wb_ack_o |-> $past(tk)) else $error("stray ack");
    a_high_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits");
    a_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("data moved");
    a_fixed_zero: assert property (rd && ix[7:0] == 8'h6e && !ix[11] |-> !wb_dat_o[5] && !wb_dat_o[0])
        else $error("fixed bit");
    a_chip_pend: assert property (rd && ix == 12'h06f |-> eventPending == (wb_dat_o[7:0] != 8'h0))
        else $error("pending");
    a_unmapped_zero: assert property (rd && ix == 12'h0ff |-> wb_dat_o == 32'h0) else $error("unmapped");
    cover property (rd && ix == 12'h06f && wb_dat_o[7]);
    cover property (rd && ix[7:0] == 8'h6e && wb_dat_o[7:0] != 8'h0);
    cover property (wb_ack_o && wb_we_i);
endmodule // isp_chk
bind isp_summary isp_chk u_chk (.*);
`default_nettype wire

// ### isp_host.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// host on the register bus
module isp_host (
    input wire logic mclk,
    input wire logic ack,
    input wire logic [31:0] rdat,
    output logic cyc,
    output logic we,
    output logic [13:0] adr,
    output logic [31:0] dat
);
    initial {cyc, we, adr, dat} = '0;
    task automatic acc(input logic w, input logic [11:0] ix, input logic [7:0] wd, output logic [7:0] rv);
        @(posedge mclk);
        cyc <= 1'b1;
        we <= w;
        adr <= {ix, 2'b00};
        dat <= {24'h0, wd};
        do @(posedge mclk); while (ack !== 1'b1);
        rv = rdat[7:0];
        cyc <= 1'b0;
        // released data inverted so a stale byte cannot pass
        dat <= ~dat;
    endtask
endmodule // isp_host
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// summary pointer bench
module tb;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [383:0] evSet = '0;
    logic cyc, we, ack, pend;
    logic [13:0] adr;
    logic [31:0] wd, rdat;
    logic [7:0] d;
    integer error_cnt = 0;
    integer n_checks = 0;
    integer seed = 88074;
    integer b;
    always #20 mclk = ~mclk;
    isp_host u_host (.mclk, .ack, .rdat, .cyc, .we, .adr, .dat(wd));
    isp_summary DUT (.mclk, .reset, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h1), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .evSet, .eventPending(pend));
    function automatic logic [7:0] ptr(integer s);
        return 8'h01 << (s < 4 ? s + 1 : s + 2);
    endfunction
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(logic [11:0] ix, logic [7:0] exp);
        u_host.acc(1'b0, ix, 8'h00, d);
        chk(d, exp);
    endtask
    task automatic pulse(logic [383:0] v);
        evSet <= v;
        @(posedge mclk);
        evSet <= '0;
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        rd(12'h06f, 8'h00);
        rd(12'h06e, 8'h00);
        pulse({12{$random(seed)}});
        rd(12'h06f, 8'h00);
        chk({7'h0, pend}, 8'h00);
        $display("mask test done");
        for (int c = 0; c < 8; c++) begin
            for (int s = 0; s < 6; s++) begin
                b = {$random(seed)} % 8;
                u_host.acc(1'b1, {1'b0, c[2:0], 8'h71 + s[7:0] + 8'(s > 3)}, 8'h00, d);
                pulse(384'h1 << (c * 48 + s * 8 + b));
                rd(12'h06f, 8'h01 << c);
                chk({7'h0, pend}, 8'h01);
                rd({1'b0, c[2:0], 8'h6e}, ptr(s));
                rd({1'b0, c[2:0], s == 5 ? 8'hd8 : 8'h69 + s[7:0]}, 8'h01 << b);
                rd({1'b0, c[2:0], 8'h6e}, 8'h00);
            end
        end
        $display("pointer test done");
        u_host.acc(1'b1, 12'h080, 8'h01, d);
        u_host.acc(1'b1, 12'h071, 8'hff, d);
        pulse(384'h1);
        rd(12'h06e, 8'h00);
        rd(12'h069, 8'h01);
        rd(12'h0ff, 8'h00);
        $display("visibility test done");
        finish_test;
    end
    initial begin
        repeat (4000) @(posedge mclk);
        error_cnt++;
        finish_test;
    end
    task finish_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
endmodule // tb
`default_nettype wire
